// ### core/fpc_pkg.sv
// Shared constants and carrier types for the flash protect controller.
// Assumes a single system clock and word-aligned byte addresses.
package fpc_pkg;

	localparam logic [15:0] FPC_KEY = 16'ha442;
	localparam int FPC_KEY_LSB = 16;
	localparam int FPC_CMD_W = 4;
	localparam int FPC_CMD_WRITE = 0;
	localparam int FPC_CMD_ERASE = 1;
	localparam int FPC_CMD_MASS_ERASE = 2;
	localparam int FPC_CMD_COMMIT = 3;
	localparam logic [7:0] FPC_USEC_RESET = 8'h31;
	localparam int FPC_USEC_W = 8;
	localparam int FPC_FLASH_LOG2 = 18;
	localparam int FPC_BLOCK_LOG2 = 10;
	localparam int FPC_GRANULE_LOG2 = 11;
	localparam int FPC_PROT_REGS = 4;
	localparam int FPC_PROT_W = 32;
	localparam int FPC_GRANULES = FPC_PROT_REGS * FPC_PROT_W;
	localparam int FPC_GRAN_W = 7;
	localparam int FPC_TIME_W = 16;
	localparam int FPC_PROG_TIME_US = 20;
	localparam int FPC_ERASE_TIME_US = 20000;
	localparam int FPC_MASS_ERASE_TIME_US = 40000;
	localparam int FPC_COMMIT_TIME_US = 20;
	localparam logic [FPC_PROT_W-1:0] FPC_PROT_RESET = 32'hffff_ffff;
	// Commit select: bit 0 picks program-enable, bits 2:1 pick the word
	localparam int FPC_COMMIT_PE_BIT = 0;
	localparam int FPC_COMMIT_IDX_LSB = 1;

	typedef struct packed {
		logic access;
		logic prog;
	} fpc_int_t;

	typedef struct packed {
		logic valid;
		logic program_sel;
		logic [1:0] index;
		logic [FPC_PROT_W-1:0] data;
	} fpc_prot_wr_t;

	typedef struct packed {
		logic valid;
		logic fetch;
		logic [31:0] addr;
	} fpc_rd_req_t;

	typedef struct packed {
		logic ack;
		logic fault;
		logic [31:0] data;
	} fpc_rd_rsp_t;

	typedef struct packed {
		logic write;
		logic erase;
		logic mass_erase;
		logic [31:0] addr;
		logic [31:0] data;
	} fpc_arr_op_t;

	typedef enum logic {FPC_IDLE, FPC_RUN} fpc_state_t;

endpackage

// ### core/fpc_array.sv
// Flash array model held in flip-flops: erase sets to ones, program ANDs.
// Assumes ops arrive as single-cycle strobes from the controller.
`timescale 1ns/10ps
module fpc_array #(
	parameter int FLASH_LOG2 = fpc_pkg::FPC_FLASH_LOG2
) (
	input wire logic clk_sys_i,
	input wire fpc_pkg::fpc_arr_op_t op_i,
	input wire logic [31:0] rd_addr_i,
	output logic [31:0] rd_data_o
);
	import fpc_pkg::*;

	localparam int ADDR_W = FLASH_LOG2 - 2;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int BLK_SHIFT = FPC_BLOCK_LOG2 - 2;

	// Contents survive system reset, as flash does
	logic [31:0] mem [DEPTH];
	logic [ADDR_W-1:0] op_word;
	logic [ADDR_W-1:0] rd_word;

	assign op_word = op_i.addr[FLASH_LOG2-1:2];
	assign rd_word = rd_addr_i[FLASH_LOG2-1:2];
	assign rd_data_o = mem[rd_word];

	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (op_i.mass_erase || (op_i.erase &&
				(ADDR_W'(i) >> BLK_SHIFT) == (op_word >> BLK_SHIFT))) begin
				mem[i] <= '1;
			end
		end
		if (op_i.write) begin
			mem[op_word] <= mem[op_word] & op_i.data;
		end
	end

endmodule

// ### core/fpc_flash_ctrl.sv
// Flash controller: op sequencing, protection bits, events, read gate.
// Assumes synchronous inputs, held read requests, and a separate
// power-on reset that is asserted together with system reset at power-up.
`timescale 1ns/10ps
module fpc_flash_ctrl #(
	parameter int FLASH_LOG2 = fpc_pkg::FPC_FLASH_LOG2,
	parameter int PROG_US = fpc_pkg::FPC_PROG_TIME_US,
	parameter int ERASE_US = fpc_pkg::FPC_ERASE_TIME_US,
	parameter int MASS_ERASE_US = fpc_pkg::FPC_MASS_ERASE_TIME_US,
	parameter int COMMIT_US = fpc_pkg::FPC_COMMIT_TIME_US
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic por_n_i,
	input wire logic nv_init_n_i,
	input wire logic usec_reload_wr_i,
	input wire logic [fpc_pkg::FPC_USEC_W-1:0] usec_reload_i,
	output logic [fpc_pkg::FPC_USEC_W-1:0] usec_reload_o,
	input wire logic ctrl_wr_i,
	input wire logic [31:0] ctrl_data_i,
	input wire logic [31:0] flash_target_address_i,
	input wire logic [31:0] flash_write_word_i,
	output logic [fpc_pkg::FPC_CMD_W-1:0] flash_control_o,
	input wire fpc_pkg::fpc_prot_wr_t prot_wr_i,
	output logic [fpc_pkg::FPC_GRANULES-1:0] program_enable_bits_o,
	output logic [fpc_pkg::FPC_GRANULES-1:0] read_enable_bits_o,
	input wire fpc_pkg::fpc_int_t ctrl_interrupt_mask_i,
	input wire fpc_pkg::fpc_int_t masked_int_status_clear_i,
	output fpc_pkg::fpc_int_t raw_int_status_o,
	output fpc_pkg::fpc_int_t masked_int_status_o,
	output logic irq_o,
	input wire fpc_pkg::fpc_rd_req_t rd_req_i,
	output fpc_pkg::fpc_rd_rsp_t rd_rsp_o
);
	import fpc_pkg::*;

	fpc_state_t state;
	logic [FPC_USEC_W-1:0] usec_cnt;
	logic [FPC_TIME_W-1:0] us_left;
	logic [FPC_CMD_W-1:0] cmd_q;
	logic [31:0] addr_q;
	logic [31:0] data_q;
	logic [FPC_GRANULES-1:0] work_pe;
	logic [FPC_GRANULES-1:0] work_re;
	logic [FPC_GRANULES-1:0] nv_pe;
	logic [FPC_GRANULES-1:0] nv_re;
	logic [FPC_GRANULES-1:0] eff_pe;
	logic [FPC_GRANULES-1:0] eff_re;
	logic [FPC_CMD_W-1:0] cmd_in;
	logic [FPC_GRAN_W-1:0] tgt_gran;
	logic [FPC_GRAN_W-1:0] rd_gran;
	logic start;
	logic refuse;
	logic tick;
	logic finish;
	logic [FPC_TIME_W-1:0] dur;
	fpc_int_t set_ev;
	fpc_int_t next_raw;
	fpc_arr_op_t arr_op;
	logic [31:0] arr_rd;
	logic [6:0] cidx;

	// Effective policy: a bit is open only while both copies are open
	assign eff_pe = work_pe & nv_pe;
	assign eff_re = work_re & nv_re;

	assign cmd_in = ctrl_data_i[FPC_CMD_W-1:0];
	assign tgt_gran = flash_target_address_i[FPC_GRANULE_LOG2 +: FPC_GRAN_W];
	assign rd_gran = rd_req_i.addr[FPC_GRANULE_LOG2 +: FPC_GRAN_W];

	// Malformed writes (bad key, zero or several bits) are ignored
	assign start = ctrl_wr_i && state == FPC_IDLE && $onehot(cmd_in) &&
		ctrl_data_i[31:FPC_KEY_LSB] == FPC_KEY;

	always_comb begin
		refuse = 1'b0;
		if (cmd_in[FPC_CMD_WRITE] || cmd_in[FPC_CMD_ERASE]) begin
			refuse = !eff_pe[tgt_gran];
		end
		// Mass erase would wipe every granule, so any lock refuses it
		if (cmd_in[FPC_CMD_MASS_ERASE]) begin
			refuse = !(&eff_pe);
		end
	end

	always_comb begin
		dur = FPC_TIME_W'(PROG_US);
		if (cmd_in[FPC_CMD_ERASE]) begin
			dur = FPC_TIME_W'(ERASE_US);
		end else if (cmd_in[FPC_CMD_MASS_ERASE]) begin
			dur = FPC_TIME_W'(MASS_ERASE_US);
		end else if (cmd_in[FPC_CMD_COMMIT]) begin
			dur = FPC_TIME_W'(COMMIT_US);
		end
	end

	assign tick = usec_cnt == '0;
	assign finish = state == FPC_RUN && tick && us_left == FPC_TIME_W'(1);

	// Cycles-per-microsecond reload, reset to the fastest-clock value
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			usec_reload_o <= FPC_USEC_RESET;
		end else if (usec_reload_wr_i) begin
			usec_reload_o <= usec_reload_i;
		end
	end

	// Microsecond prescaler; a reload mid-operation takes effect next tick
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			usec_cnt <= '0;
		end else if (state == FPC_IDLE || tick) begin
			usec_cnt <= usec_reload_o;
		end else begin
			usec_cnt <= usec_cnt - FPC_USEC_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= FPC_IDLE;
			us_left <= '0;
			cmd_q <= '0;
			addr_q <= '0;
			data_q <= '0;
			flash_control_o <= '0;
		end else begin
			unique case (state)
				FPC_IDLE: begin
					if (start && !refuse) begin
						state <= FPC_RUN;
						us_left <= dur;
						cmd_q <= cmd_in;
						addr_q <= flash_target_address_i;
						data_q <= flash_write_word_i;
						flash_control_o <= cmd_in;
					end
				end
				FPC_RUN: begin
					if (finish) begin
						state <= FPC_IDLE;
						flash_control_o <= '0;
					end else if (tick) begin
						us_left <= us_left - FPC_TIME_W'(1);
					end
				end
			endcase
		end
	end

	// Array is touched only at the end of an accepted operation
	always_comb begin
		arr_op.write = finish && cmd_q[FPC_CMD_WRITE];
		arr_op.erase = finish && cmd_q[FPC_CMD_ERASE];
		arr_op.mass_erase = finish && cmd_q[FPC_CMD_MASS_ERASE];
		arr_op.addr = addr_q;
		arr_op.data = data_q;
	end

	fpc_array #(
		.FLASH_LOG2(FLASH_LOG2)
	) u_array (
		.clk_sys_i(clk_sys_i),
		.op_i(arr_op),
		.rd_addr_i(rd_req_i.addr),
		.rd_data_o(arr_rd)
	);

	// Working copy: only power-on reset restores it, system reset does not
	always_ff @(posedge clk_sys_i or negedge por_n_i) begin
		if (!por_n_i) begin
			work_pe <= {FPC_PROT_REGS{FPC_PROT_RESET}};
			work_re <= {FPC_PROT_REGS{FPC_PROT_RESET}};
		end else if (prot_wr_i.valid) begin
			// AND keeps cleared bits cleared
			if (prot_wr_i.program_sel) begin
				work_pe[prot_wr_i.index*FPC_PROT_W +: FPC_PROT_W] <=
					work_pe[prot_wr_i.index*FPC_PROT_W +: FPC_PROT_W] &
					prot_wr_i.data;
			end else begin
				work_re[prot_wr_i.index*FPC_PROT_W +: FPC_PROT_W] <=
					work_re[prot_wr_i.index*FPC_PROT_W +: FPC_PROT_W] &
					prot_wr_i.data;
			end
		end
	end

	assign cidx = {addr_q[FPC_COMMIT_IDX_LSB +: 2], 5'h00};

	// Nonvolatile copy: only the factory-init pin brings it back to ones
	always_ff @(posedge clk_sys_i or negedge nv_init_n_i) begin
		if (!nv_init_n_i) begin
			nv_pe <= {FPC_PROT_REGS{FPC_PROT_RESET}};
			nv_re <= {FPC_PROT_REGS{FPC_PROT_RESET}};
		end else if (finish && cmd_q[FPC_CMD_COMMIT]) begin
			if (addr_q[FPC_COMMIT_PE_BIT]) begin
				nv_pe[cidx +: FPC_PROT_W] <= nv_pe[cidx +: FPC_PROT_W] &
					work_pe[cidx +: FPC_PROT_W];
			end else begin
				nv_re[cidx +: FPC_PROT_W] <= nv_re[cidx +: FPC_PROT_W] &
					work_re[cidx +: FPC_PROT_W];
			end
		end
	end

	// Mirror lags the checks by one cycle; the checks use the live value
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			program_enable_bits_o <= '1;
			read_enable_bits_o <= '1;
		end else begin
			program_enable_bits_o <= eff_pe;
			read_enable_bits_o <= eff_re;
		end
	end

	always_comb begin
		set_ev.access = start && refuse;
		set_ev.prog = finish && !cmd_q[FPC_CMD_COMMIT];
		// Set wins over a clear in the same cycle
		next_raw = (raw_int_status_o & ~masked_int_status_clear_i) |
			set_ev;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			raw_int_status_o <= '0;
			masked_int_status_o <= '0;
			irq_o <= 1'b0;
		end else begin
			raw_int_status_o <= next_raw;
			masked_int_status_o <= next_raw & ctrl_interrupt_mask_i;
			irq_o <= |(next_raw & ctrl_interrupt_mask_i);
		end
	end

	// Reads answer only while idle, so fetches wait out any operation
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_rsp_o <= '0;
		end else begin
			rd_rsp_o.ack <= rd_req_i.valid && !rd_rsp_o.ack &&
				state == FPC_IDLE;
			rd_rsp_o.fault <= !rd_req_i.fetch &&
				!eff_re[rd_gran];
			rd_rsp_o.data <= (rd_req_i.fetch || eff_re[rd_gran]) ?
				arr_rd : '0;
		end
	end

	property p_stall_busy;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		state == FPC_RUN |=> !rd_rsp_o.ack;
	endproperty
	a_stall_busy: assert property (p_stall_busy)
		else $error("read answered during an operation");

	property p_fetch_no_fault;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_req_i.valid && rd_req_i.fetch ##1 rd_rsp_o.ack |-> !rd_rsp_o.fault;
	endproperty
	a_fetch_no_fault: assert property (p_fetch_no_fault)
		else $error("instruction fetch faulted");

	property p_data_fault;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_req_i.valid && !rd_req_i.fetch && !eff_re[rd_gran]
			##1 rd_rsp_o.ack |-> rd_rsp_o.fault && rd_rsp_o.data == '0;
	endproperty
	a_data_fault: assert property (p_data_fault)
		else $error("protected data read not faulted");

	property p_refuse;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		start && refuse |=> raw_int_status_o.access &&
			flash_control_o == '0 && state == FPC_IDLE;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("refused operation started or not flagged");

	property p_done_sets_prog;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		$fell(|flash_control_o[FPC_CMD_MASS_ERASE:FPC_CMD_WRITE]) |->
			raw_int_status_o.prog;
	endproperty
	a_done_sets_prog: assert property (p_done_sets_prog)
		else $error("completion status not set");

	property p_masked;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		##1 masked_int_status_o ==
			(raw_int_status_o & $past(ctrl_interrupt_mask_i)) &&
			irq_o == |masked_int_status_o;
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked status does not follow mask");

	property p_clear;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		masked_int_status_clear_i.prog && !set_ev.prog |=>
			!raw_int_status_o.prog && !masked_int_status_o.prog;
	endproperty
	a_clear: assert property (p_clear)
		else $error("write one did not clear status");

	property p_sticky;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		raw_int_status_o.access && !masked_int_status_clear_i.access |=>
			raw_int_status_o.access;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("access status dropped without clear");

	property p_only_clear;
		@(posedge clk_sys_i) disable iff (!resetn_i || !por_n_i)
		##1 (work_pe & ~$past(work_pe)) == '0 &&
			(work_re & ~$past(work_re)) == '0;
	endproperty
	a_only_clear: assert property (p_only_clear)
		else $error("protection bit went from zero to one");

	property p_op_length;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		start && !refuse && cmd_in[FPC_CMD_WRITE] &&
			usec_reload_o == '0 |-> ##PROG_US
			flash_control_o[FPC_CMD_WRITE] ##1 flash_control_o == '0;
	endproperty
	a_op_length: assert property (p_op_length)
		else $error("write length does not follow the reload value");

	c_refused: cover property (@(posedge clk_sys_i) start && refuse);
	c_write_done: cover property (@(posedge clk_sys_i)
		finish && cmd_q[FPC_CMD_WRITE]);
	c_commit_done: cover property (@(posedge clk_sys_i)
		finish && cmd_q[FPC_CMD_COMMIT]);
	c_data_fault: cover property (@(posedge clk_sys_i)
		rd_rsp_o.ack && rd_rsp_o.fault);

endmodule

// ### tb/fpc_bus_master_model.sv
// Bus master model: instruction fetches and data reads of the flash.
// Assumes the controller acks a held request within a bounded time.
`timescale 1ns/10ps
module fpc_bus_master_model (
	input wire logic clk_sys_i,
	input wire fpc_pkg::fpc_rd_rsp_t rd_rsp_i,
	output fpc_pkg::fpc_rd_req_t rd_req_o
);
	import fpc_pkg::*;

	initial rd_req_o = '{valid: 1'b0, fetch: 1'b0, addr: 32'h0};

	// Held until ack or for at most 300 cycles; the released address is inverted so that a stale
	// address never looks like a live one
	task automatic read(input logic fetch, input logic [31:0] addr,
		output logic [31:0] data, output logic fault, output logic ok);
		data = 32'h0;
		fault = 1'b0;
		ok = 1'b0;
		@(posedge clk_sys_i);
		rd_req_o <= '{valid: 1'b1, fetch: fetch, addr: addr};
		repeat (300) begin
			@(posedge clk_sys_i);
			if (rd_rsp_i.ack === 1'b1) begin
				data = rd_rsp_i.data;
				fault = rd_rsp_i.fault;
				ok = 1'b1;
				break;
			end
		end
		rd_req_o <= '{valid: 1'b0, fetch: 1'b0, addr: ~addr};
	endtask
endmodule

// ### tb/flash_protect_controller_test.sv
// Self-checking bench for the flash protect controller.
// Assumes short operation times set by parameters and an 8 KB array.
`timescale 1ns/10ps
module flash_protect_controller_test;
	import fpc_pkg::*;
	localparam int PUS = 2;
	localparam int EUS = 3;
	localparam int MUS = 4;
	localparam int CUS = 2;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic por_n_i = 1'b0;
	logic nv_init_n_i = 1'b0;
	logic rl_wr = 1'b0;
	logic [7:0] rl_in = 8'h00;
	logic ctrl_wr = 1'b0;
	logic [31:0] ctrl_data = 32'h0;
	logic [31:0] addr_in = 32'h0;
	logic [31:0] word_in = 32'h0;
	fpc_prot_wr_t prot = '0;
	fpc_int_t mask = '0;
	fpc_int_t clr = '0;
	fpc_rd_req_t rd_req;
	fpc_rd_rsp_t rd_rsp;
	logic [7:0] usec_o;
	logic [3:0] ctl_o;
	logic [127:0] pe_o;
	logic [127:0] re_o;
	fpc_int_t raw_o;
	fpc_int_t msk_o;
	logic irq;
	int n_mismatch = 0;
	int num_checks = 0;
	int rl = 0;
	logic [31:0] rd;
	logic flt;
	logic ok;

	always #2.5 clk_sys_i = ~clk_sys_i;

	fpc_flash_ctrl #(.FLASH_LOG2(13), .PROG_US(PUS), .ERASE_US(EUS),
		.MASS_ERASE_US(MUS), .COMMIT_US(CUS)) DUT (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .por_n_i(por_n_i),
		.nv_init_n_i(nv_init_n_i), .usec_reload_wr_i(rl_wr),
		.usec_reload_i(rl_in), .usec_reload_o(usec_o),
		.ctrl_wr_i(ctrl_wr), .ctrl_data_i(ctrl_data),
		.flash_target_address_i(addr_in), .flash_write_word_i(word_in),
		.flash_control_o(ctl_o), .prot_wr_i(prot),
		.program_enable_bits_o(pe_o), .read_enable_bits_o(re_o),
		.ctrl_interrupt_mask_i(mask), .masked_int_status_clear_i(clr),
		.raw_int_status_o(raw_o), .masked_int_status_o(msk_o),
		.irq_o(irq), .rd_req_i(rd_req), .rd_rsp_o(rd_rsp));

	fpc_bus_master_model master (.clk_sys_i(clk_sys_i),
		.rd_rsp_i(rd_rsp), .rd_req_o(rd_req));

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	task automatic rst(input logic nv);
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		por_n_i <= 1'b0;
		nv_init_n_i <= nv;
		tick(4);
		resetn_i <= 1'b1;
		por_n_i <= 1'b1;
		nv_init_n_i <= 1'b1;
		tick(2);
	endtask

	task automatic set_reload(input logic [7:0] v);
		@(posedge clk_sys_i);
		rl_wr <= 1'b1;
		rl_in <= v;
		@(posedge clk_sys_i);
		rl_wr <= 1'b0;
		rl = v;
		tick(1);
		chk("reload", {24'h0, v}, {24'h0, usec_o});
	endtask

	task automatic protw(input logic pe, input logic [31:0] d);
		@(posedge clk_sys_i);
		prot <= '{valid: 1'b1, program_sel: pe, index: 2'h0, data: d};
		@(posedge clk_sys_i);
		prot.valid <= 1'b0;
		tick(2);
	endtask

	task automatic clear(input fpc_int_t c);
		@(posedge clk_sys_i);
		clr <= c;
		@(posedge clk_sys_i);
		clr <= '0;
		tick(1);
	endtask

	// us of zero means the command must be refused or ignored and never run
	task automatic op(input logic [15:0] key, input int cmd,
		input logic [31:0] a, input logic [31:0] w, input int us);
		int n;
		int e;
		n = 0;
		e = us * (rl + 1);
		@(posedge clk_sys_i);
		addr_in <= a;
		word_in <= w;
		@(posedge clk_sys_i);
		ctrl_wr <= 1'b1;
		ctrl_data <= {key, 12'h000, 4'(1 << cmd)};
		@(posedge clk_sys_i);
		ctrl_wr <= 1'b0;
		repeat (400) begin
			@(posedge clk_sys_i);
			if (ctl_o === 4'h0)
				break;
			if (n == 0)
				chk("cmd_bit", 32'(1 << cmd), {28'h0, ctl_o});
			n++;
		end
		if (ctl_o !== 4'h0) begin
			n_mismatch++;
			tally_and_finish();
		end
		chk("op_len", 32'h1, {31'h0, us == 0 ? n == 0 :
			(n >= e - 1 && n <= e)});
	endtask

	task automatic rdchk(input logic f, input logic [31:0] a,
		input logic [31:0] ed, input logic ef);
		master.read(f, a, rd, flt, ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			tally_and_finish();
		end
		chk("rd_data", ed, rd);
		chk("rd_fault", {31'h0, ef}, {31'h0, flt});
	endtask

	initial begin
		rst(1'b0);
		chk("usec_rst", 32'h31, {24'h0, usec_o});
		chk("pe_rst", 32'hffffffff, pe_o[31:0]);
		chk("re_rst", 32'hffffffff, re_o[31:0]);
		chk("raw_rst", 32'h0, {30'h0, raw_o});
		set_reload(8'h01);
		mask <= '{access: 1'b1, prog: 1'b0};
		op(16'h0000, FPC_CMD_ERASE, 32'h0, 32'h0, 0);
		op(FPC_KEY, FPC_CMD_ERASE, 32'h000, 32'h0, EUS);
		op(FPC_KEY, FPC_CMD_ERASE, 32'h400, 32'h0, EUS);
		op(FPC_KEY, FPC_CMD_ERASE, 32'h800, 32'h0, EUS);
		chk("raw_prog", 32'h1, {30'h0, raw_o});
		chk("msk_off", 32'h0, {30'h0, msk_o});
		chk("irq_off", 32'h0, {31'h0, irq});
		rdchk(1'b0, 32'h7fc, 32'hffffffff, 1'b0);
		clear('{access: 1'b0, prog: 1'b1});
		chk("raw_clr", 32'h0, {30'h0, raw_o});
		op(FPC_KEY, FPC_CMD_WRITE, 32'h4, 32'ha5a50f0f, PUS);
		op(FPC_KEY, FPC_CMD_WRITE, 32'h4, 32'hffff00ff, PUS);
		rdchk(1'b0, 32'h4, 32'ha5a5000f, 1'b0);
		rdchk(1'b0, 32'h8, 32'hffffffff, 1'b0);
		mask <= '{access: 1'b1, prog: 1'b1};
		tick(2);
		chk("msk_prog", 32'h1, {30'h0, msk_o});
		chk("irq_prog", 32'h1, {31'h0, irq});
		clear('{access: 1'b1, prog: 1'b1});
		chk("msk_clr", 32'h0, {30'h0, msk_o});
		chk("raw_clr2", 32'h0, {30'h0, raw_o});
		protw(1'b1, 32'hfffffffd);
		chk("pe_clr", 32'hfffffffd, pe_o[31:0]);
		protw(1'b1, 32'hffffffff);
		chk("pe_keep", 32'hfffffffd, pe_o[31:0]);
		op(FPC_KEY, FPC_CMD_WRITE, 32'h800, 32'h0, 0);
		chk("raw_acc", 32'h2, {30'h0, raw_o});
		chk("irq_acc", 32'h1, {31'h0, irq});
		rdchk(1'b0, 32'h800, 32'hffffffff, 1'b0);
		clear('{access: 1'b1, prog: 1'b0});
		mask <= '{access: 1'b0, prog: 1'b1};
		op(FPC_KEY, FPC_CMD_ERASE, 32'h800, 32'h0, 0);
		op(FPC_KEY, FPC_CMD_MASS_ERASE, 32'h0, 32'h0, 0);
		chk("raw_acc2", 32'h2, {30'h0, raw_o});
		chk("irq_mask", 32'h0, {31'h0, irq});
		rdchk(1'b0, 32'h804, 32'hffffffff, 1'b0);
		clear('{access: 1'b1, prog: 1'b0});
		protw(1'b0, 32'hfffffffe);
		chk("re_clr", 32'hfffffffe, re_o[31:0]);
		rdchk(1'b0, 32'h4, 32'h0, 1'b1);
		rdchk(1'b1, 32'h4, 32'ha5a5000f, 1'b0);
		op(FPC_KEY, FPC_CMD_WRITE, 32'h8, 32'h12345678, PUS);
		rdchk(1'b1, 32'h8, 32'h12345678, 1'b0);
		fork
			op(FPC_KEY, FPC_CMD_ERASE, 32'h400, 32'h0, EUS);
			begin
				tick(3);
				rdchk(1'b1, 32'h4, 32'ha5a5000f, 1'b0);
				chk("stall", 32'h0, {28'h0, ctl_o});
			end
		join
		rst(1'b1);
		chk("pe_por", 32'hffffffff, pe_o[31:0]);
		chk("re_por", 32'hffffffff, re_o[31:0]);
		set_reload(8'h00);
		op(FPC_KEY, FPC_CMD_MASS_ERASE, 32'h0, 32'h0, MUS);
		rdchk(1'b0, 32'h8, 32'hffffffff, 1'b0);
		op(FPC_KEY, FPC_CMD_WRITE, 32'hc, 32'h0f0f0f0f, PUS);
		rdchk(1'b0, 32'hc, 32'h0f0f0f0f, 1'b0);
		clear('{access: 1'b1, prog: 1'b1});
		protw(1'b1, 32'hfffffffb);
		protw(1'b0, 32'hfffffffd);
		op(FPC_KEY, FPC_CMD_COMMIT, 32'h1, 32'h0, CUS);
		op(FPC_KEY, FPC_CMD_COMMIT, 32'h0, 32'h0, CUS);
		chk("commit_raw", 32'h0, {30'h0, raw_o});
		rst(1'b1);
		chk("pe_commit", 32'hfffffffb, pe_o[31:0]);
		chk("re_commit", 32'hfffffffd, re_o[31:0]);
		tally_and_finish();
	end
endmodule
